// file: hdl/nbx_pkg.sv
// shared constants and types for the nibble bus io expander
package nbx_pkg;
   localparam int NBX_NIBBLE_W = 4;
   localparam int NBX_PORT_COUNT = 4;
   localparam int NBX_PORT_NUM_BASE = 4;
   localparam int NBX_ADDR_LSB = 0;
   localparam int NBX_ADDR_MSB = 1;
   localparam int NBX_OP_LSB = 2;
   localparam int NBX_OP_MSB = 3;
   localparam logic [1:0] NBX_OP_READ = 2'h0;
   localparam logic [1:0] NBX_OP_DIRECT = 2'h1;
   localparam logic [1:0] NBX_OP_OR = 2'h2;
   localparam logic [1:0] NBX_OP_AND = 2'h3;
   localparam logic [3:0] NBX_PORT_RESET = 4'h0;
   // strobe low time and phase setup and hold times, ns and cycles at 100 MHz
   localparam int NBX_CLK_NS = 10;
   localparam int NBX_STROBE_LOW_NS = 700;
   localparam int NBX_SETUP_NS = 200;
   localparam int NBX_HOLD_NS = 100;
   localparam int NBX_STROBE_LOW_CYC = (NBX_STROBE_LOW_NS + NBX_CLK_NS - 1) / NBX_CLK_NS;
   localparam int NBX_SETUP_CYC = (NBX_SETUP_NS + NBX_CLK_NS - 1) / NBX_CLK_NS;
   localparam int NBX_HOLD_CYC = (NBX_HOLD_NS + NBX_CLK_NS - 1) / NBX_CLK_NS;
   localparam int NBX_CNT_W = 8;
   typedef enum logic [2:0] {
      NBX_H_IDLE, NBX_H_CMD, NBX_H_LOW, NBX_H_DATA, NBX_H_HOLD
   } nbx_host_state_type;
endpackage

// file: hdl/nbx_link_if.sv
// interface joining the host end and the expander end of the nibble bus
`timescale 1ns/10ps
`default_nettype none
interface nbx_link_if;
   logic transfer_strobe;
   logic chip_select_n;
   logic [3:0] host_bus_out;
   logic host_bus_oe;
   logic [3:0] dev_bus_out;
   logic dev_bus_oe;
   logic [3:0] host_nibble_bus;
   // resolved bus level; undriven reads as zero
   assign host_nibble_bus = host_bus_oe ? host_bus_out : (dev_bus_oe ? dev_bus_out : 4'h0);
   modport host (
      output transfer_strobe,
      output chip_select_n,
      output host_bus_out,
      output host_bus_oe,
      input host_nibble_bus
   );
   modport dev (
      input transfer_strobe,
      input chip_select_n,
      output dev_bus_out,
      output dev_bus_oe,
      input host_nibble_bus
   );
endinterface
`default_nettype wire

// file: hdl/nbx_expander.sv
// expander end: four 4-bit ports driven by nibble bus transfers
`timescale 1ns/10ps
`default_nettype none
module nbx_expander
   import nbx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   nbx_link_if.dev link,
   input wire logic [15:0] port_pin_in,
   output logic [15:0] port_pin_out,
   output logic [3:0] port_oe,
   output logic powerup_q_out
);
   // each off-domain input passes its own three-flop synchroniser
   logic strb_s;
   logic cs_n_s;
   logic [3:0] bus_s;
   logic [15:0] pin_s;
   logic strb_prev_q, strb_prev_d;
   logic fall, rise, cs_act;

   nbx_sync3 #(.W(1), .RST(1'b1)) nbx_sync3_strb_inst (
      .clk(clk),
      .rst_n(rst_n),
      .din(link.transfer_strobe),
      .dout(strb_s)
   );
   // select resets inactive, so a reset never opens a frame
   nbx_sync3 #(.W(1), .RST(1'b1)) nbx_sync3_cs_inst (
      .clk(clk),
      .rst_n(rst_n),
      .din(link.chip_select_n),
      .dout(cs_n_s)
   );
   // bus word filtered whole; same lag as the strobe, so they line up
   nbx_sync3 #(.W(4), .RST(4'h0)) nbx_sync3_bus_inst (
      .clk(clk),
      .rst_n(rst_n),
      .din(link.host_nibble_bus),
      .dout(bus_s)
   );
   // pins sampled the same way; a read returns the filtered word
   nbx_sync3 #(.W(16), .RST(16'h0000)) nbx_sync3_pin_inst (
      .clk(clk),
      .rst_n(rst_n),
      .din(port_pin_in),
      .dout(pin_s)
   );

   // strobe history resets to its idle high level: no false edge after reset
   always_comb begin
      strb_prev_d = strb_s;
      fall = strb_prev_q & ~strb_s;
      rise = ~strb_prev_q & strb_s;
      cs_act = ~cs_n_s;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         strb_prev_q <= 1'b1;
      end else begin
         strb_prev_q <= strb_prev_d;
      end
   end

   // transfer state: latched command, port values, drive enables
   logic [1:0] op_q, op_d;
   logic [1:0] addr_q, addr_d;
   logic in_xfer_q, in_xfer_d;
   logic powerup_q, powerup_d;
   logic [15:0] val_q, val_d;
   logic [3:0] oe_q, oe_d;
   logic [3:0] rd_data_q, rd_data_d;
   logic bus_oe_q, bus_oe_d;
   logic [3:0] old_v, new_v, data_v;

   always_comb begin
      op_d = op_q;
      addr_d = addr_q;
      in_xfer_d = in_xfer_q;
      powerup_d = powerup_q;
      val_d = val_q;
      oe_d = oe_q;
      rd_data_d = rd_data_q;
      bus_oe_d = 1'b0;
      old_v = val_q[addr_q*NBX_NIBBLE_W +: NBX_NIBBLE_W];
      data_v = bus_s;
      new_v = old_v;
      // deselected: only the bus drive changes (it drops), edges are dropped
      if (cs_act) begin
         if (fall) begin
            op_d = bus_s[NBX_OP_MSB:NBX_OP_LSB];
            addr_d = bus_s[NBX_ADDR_MSB:NBX_ADDR_LSB];
            in_xfer_d = 1'b1;
            powerup_d = 1'b0;
            if (bus_s[NBX_OP_MSB:NBX_OP_LSB] == NBX_OP_READ) begin
               oe_d[bus_s[NBX_ADDR_MSB:NBX_ADDR_LSB]] = 1'b0;
            end
         end else if (rise && in_xfer_q) begin
            in_xfer_d = 1'b0;
            if (op_q == NBX_OP_READ) begin
               oe_d[addr_q] = 1'b0;
            end else begin
               case (op_q)
                  NBX_OP_DIRECT: new_v = data_v;
                  NBX_OP_OR: new_v = old_v | data_v;
                  default: new_v = old_v & data_v;
               endcase
               val_d[addr_q*NBX_NIBBLE_W +: NBX_NIBBLE_W] = new_v;
               oe_d[addr_q] = 1'b1;
            end
         end
         // read keeps the latch, only sampled pins go out
         if (in_xfer_d && op_d == NBX_OP_READ && !rise) begin
            rd_data_d = pin_s[addr_d*NBX_NIBBLE_W +: NBX_NIBBLE_W];
            bus_oe_d = 1'b1;
         end
      end
   end

   // all ports tri-state until the first write rise, bus released until the first read fall
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= NBX_OP_READ;
         addr_q <= 2'h0;
         in_xfer_q <= 1'b0;
         powerup_q <= 1'b1;
         val_q <= {NBX_PORT_COUNT{NBX_PORT_RESET}};
         oe_q <= 4'h0;
         rd_data_q <= 4'h0;
         bus_oe_q <= 1'b0;
      end else begin
         op_q <= op_d;
         addr_q <= addr_d;
         in_xfer_q <= in_xfer_d;
         powerup_q <= powerup_d;
         val_q <= val_d;
         oe_q <= oe_d;
         rd_data_q <= rd_data_d;
         bus_oe_q <= bus_oe_d;
      end
   end

   // outputs come straight from registers
   assign port_pin_out = val_q;
   assign port_oe = oe_q;
   assign powerup_q_out = powerup_q;
   assign link.dev_bus_out = rd_data_q;
   assign link.dev_bus_oe = bus_oe_q;
endmodule

// three-flop synchroniser; output moves once stages two and three agree
module nbx_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = {W{1'b0}}
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q, s1_d, s2_q, s2_d;
   logic [W-1:0] s3_q, s3_d, out_q, out_d;
   // a word caught mid-change in stage one never reaches dout
   always_comb begin
      s1_d = din;
      s2_d = s1_q;
      s3_d = s2_q;
      out_d = (s2_q == s3_q) ? s3_q : out_q;
   end
   // registers only; reset loads the idle level of the input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         out_q <= RST;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         out_q <= out_d;
      end
   end
   assign dout = out_q;
endmodule
`default_nettype wire

// file: hdl/nbx_host.sv
// host end: sequences command and data nibbles with the strobe
`timescale 1ns/10ps
`default_nettype none
module nbx_host
   import nbx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   nbx_link_if.host link,
   input wire logic req_valid,
   input wire logic [1:0] req_op,
   input wire logic [1:0] req_port,
   input wire logic [3:0] req_data,
   output logic req_ready,
   output logic rsp_valid,
   output logic [3:0] rsp_data
);
   nbx_host_state_type st_q, st_d;
   logic [NBX_CNT_W-1:0] cnt_q, cnt_d;
   logic [3:0] cmd_q, cmd_d, dat_q, dat_d;
   logic strb_q, strb_d, cs_n_q, cs_n_d, oe_q, oe_d;
   logic [3:0] out_q, out_d;
   logic rv_q, rv_d, rdy_q, rdy_d;
   logic [3:0] rd_q, rd_d;

   // command at fall, data (or sampling) ahead of rise
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      cmd_d = cmd_q;
      dat_d = dat_q;
      strb_d = strb_q;
      cs_n_d = cs_n_q;
      oe_d = oe_q;
      out_d = out_q;
      rv_d = 1'b0;
      rd_d = rd_q;
      rdy_d = 1'b0;
      case (st_q)
         NBX_H_IDLE: begin
            rdy_d = 1'b1;
            if (req_valid && rdy_q) begin
               cmd_d = {req_op, req_port};
               dat_d = req_data;
               cs_n_d = 1'b0;
               oe_d = 1'b1;
               out_d = {req_op, req_port};
               cnt_d = 8'(NBX_SETUP_CYC);
               rdy_d = 1'b0;
               st_d = NBX_H_CMD;
            end
         end
         NBX_H_CMD: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
               strb_d = 1'b0;
               cnt_d = 8'(NBX_HOLD_CYC);
               st_d = NBX_H_LOW;
            end
         end
         NBX_H_LOW: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
               // read: hand the bus to the expander
               oe_d = (cmd_q[3:2] != NBX_OP_READ);
               out_d = dat_q;
               cnt_d = 8'(NBX_STROBE_LOW_CYC);
               st_d = NBX_H_DATA;
            end
         end
         NBX_H_DATA: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
               rd_d = link.host_nibble_bus;
               strb_d = 1'b1;
               cnt_d = 8'(NBX_HOLD_CYC);
               st_d = NBX_H_HOLD;
            end
         end
         default: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h00) begin
               oe_d = 1'b0;
               cs_n_d = 1'b1;
               rv_d = (cmd_q[3:2] == NBX_OP_READ); // left to the user
               st_d = NBX_H_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= NBX_H_IDLE;
         cnt_q <= 8'h00;
         cmd_q <= 4'h0;
         dat_q <= 4'h0;
         strb_q <= 1'b1;
         cs_n_q <= 1'b1;
         oe_q <= 1'b0;
         out_q <= 4'h0;
         rv_q <= 1'b0;
         rd_q <= 4'h0;
         rdy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         cmd_q <= cmd_d;
         dat_q <= dat_d;
         strb_q <= strb_d;
         cs_n_q <= cs_n_d;
         oe_q <= oe_d;
         out_q <= out_d;
         rv_q <= rv_d;
         rd_q <= rd_d;
         rdy_q <= rdy_d;
      end
   end

   assign link.transfer_strobe = strb_q;
   assign link.chip_select_n = cs_n_q;
   assign link.host_bus_oe = oe_q;
   assign link.host_bus_out = out_q;
   assign req_ready = rdy_q;
   assign rsp_valid = rv_q;
   assign rsp_data = rd_q;
endmodule
`default_nettype wire

// file: bench/nbx_link_checker.sv
// checker for nibble bus transfers between the host and expander ends
`timescale 1ns/10ps
`default_nettype none
module nbx_link_checker
   import nbx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic transfer_strobe,
   input wire logic chip_select_n,
   input wire logic [3:0] host_bus_out,
   input wire logic host_bus_oe,
   input wire logic dev_bus_oe,
   input wire logic [3:0] host_nibble_bus
);
   logic [1:0] op_q, op_d;
   logic [7:0] low_q, low_d;
   // op taken at first low cycle; low count saturates
   always_comb begin
      op_d = op_q;
      low_d = transfer_strobe ? 8'h00 : ((low_q == 8'hFF) ? low_q : low_q + 8'h01);
      if (!transfer_strobe && low_q == 8'h00) begin
         op_d = host_nibble_bus[NBX_OP_MSB:NBX_OP_LSB];
      end
   end
   // helper registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q <= NBX_OP_READ;
         low_q <= 8'h00;
      end else begin
         op_q <= op_d;
         low_q <= low_d;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // device needs a few cycles to see the fall, hence the margin
   sequence s_read_held;
      !transfer_strobe && op_q == NBX_OP_READ && low_q >= 8'h08;
   endsequence
   sequence s_write_low;
      !transfer_strobe && op_q != NBX_OP_READ && low_q >= 8'h01;
   endsequence
   AST_DESEL_QUIET: assert property (chip_select_n |-> !dev_bus_oe)
      else $error("bus driven while deselected");
   AST_CMD_QUIET: assert property (transfer_strobe && $past(transfer_strobe, 6) |-> !dev_bus_oe)
      else $error("bus driven in command phase");
   AST_READ_DRIVES: assert property (s_read_held |-> dev_bus_oe)
      else $error("read data not driven");
   AST_WRITE_QUIET: assert property (s_write_low |-> !dev_bus_oe)
      else $error("bus driven during write");
   AST_RELEASE_AT_RISE: assert property ($rose(transfer_strobe) |-> ##[1:6] !dev_bus_oe)
      else $error("bus not released after rise");
   AST_CMD_SETUP: assert property ($fell(transfer_strobe) |->
      host_bus_oe && $past(host_bus_out, 10) == host_bus_out)
      else $error("command nibble not stable at fall");
   AST_DATA_SETUP: assert property ($rose(transfer_strobe) && op_q != NBX_OP_READ |->
      $past(host_bus_oe) && $past(host_bus_out) == $past(host_bus_out, 20))
      else $error("data nibble not stable at rise");
   AST_CS_FRAMES: assert property ($changed(transfer_strobe) |->
      !chip_select_n && $past(!chip_select_n))
      else $error("strobe edge outside chip select");
   AST_LOW_WIDTH: assert property ($rose(transfer_strobe) |->
      $past(low_q) >= NBX_STROBE_LOW_CYC)
      else $error("strobe low too short");
endmodule
`default_nettype wire

// file: bench/test_nibble_bus_io_expander.sv
// testbench joining host and expander ends over the nibble bus
`timescale 1ns/10ps
`default_nettype none
module test_nibble_bus_io_expander;
   import nbx_pkg::*;
   logic clk, rst_n, req_valid, req_ready, rsp_valid, powerup_q_out;
   logic [1:0] req_op, req_port;
   logic [3:0] req_data, rsp_data, port_oe, exp_oe, got;
   logic [15:0] port_pin_in, port_pin_out, exp_out;
   int miscompares, total_checks;
   nbx_link_if nbx_link_if_inst ();
   nbx_host nbx_host_inst (.clk(clk), .rst_n(rst_n), .link(nbx_link_if_inst.host),
      .req_valid(req_valid), .req_op(req_op), .req_port(req_port), .req_data(req_data),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   nbx_expander nbx_expander_inst (.clk(clk), .rst_n(rst_n), .link(nbx_link_if_inst.dev),
      .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_oe(port_oe),
      .powerup_q_out(powerup_q_out));
   nbx_link_checker nbx_link_checker_inst (.clk(clk), .rst_n(rst_n),
      .transfer_strobe(nbx_link_if_inst.transfer_strobe),
      .chip_select_n(nbx_link_if_inst.chip_select_n),
      .host_bus_out(nbx_link_if_inst.host_bus_out), .host_bus_oe(nbx_link_if_inst.host_bus_oe),
      .dev_bus_oe(nbx_link_if_inst.dev_bus_oe),
      .host_nibble_bus(nbx_link_if_inst.host_nibble_bus));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic complete_run();
      if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_nib(input logic [3:0] g, input logic [3:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t nibble got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t flag got %b exp %b", $time, g, e);
      end
   endtask
   // one host request; read data lands in got only if rsp_valid pulses
   task automatic xfer(input logic [1:0] op, input logic [1:0] prt, input logic [3:0] d);
      int n;
      n = 0;
      got = 4'hX;
      while (req_ready !== 1'b1 && n < 300) begin
         @(posedge clk);
         n++;
      end
      req_op <= op;
      req_port <= prt;
      req_data <= d;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (rsp_valid === 1'b1) got = rsp_data;
      end while (req_ready !== 1'b1 && n < 300);
   endtask
   // request plus model update and full port comparison
   task automatic do_op(input logic [1:0] op, input logic [1:0] prt, input logic [3:0] d);
      logic [3:0] old;
      old = exp_out[prt*4 +: 4];
      xfer(op, prt, d);
      case (op)
         NBX_OP_DIRECT: exp_out[prt*4 +: 4] = d;
         NBX_OP_OR: exp_out[prt*4 +: 4] = old | d;
         NBX_OP_AND: exp_out[prt*4 +: 4] = old & d;
         default: chk_nib(got, port_pin_in[prt*4 +: 4]);
      endcase
      exp_oe[prt] = (op != NBX_OP_READ);
      chk_nib(port_oe, exp_oe);
      for (int i = 0; i < 4; i++) chk_nib(port_pin_out[i*4 +: 4], exp_out[i*4 +: 4]);
      chk_bit(powerup_q_out, 1'b0);
      chk_bit(nbx_link_if_inst.dev_bus_oe, 1'b0);
   endtask
   // watchdog: a full run takes about 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("[ERR] %0t watchdog expired", $time);
      complete_run();
   end
   // main sequence
   initial begin
      rst_n = 1'b0;
      req_valid = 1'b0;
      req_op = 2'h0;
      req_port = 2'h0;
      req_data = 4'h0;
      port_pin_in = 16'h9C3A;
      exp_out = 16'h0000;
      exp_oe = 4'h0;
      miscompares = 0;
      total_checks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      chk_nib(port_oe, 4'h0);
      chk_bit(nbx_link_if_inst.dev_bus_oe, 1'b0);
      chk_bit(powerup_q_out, 1'b1);
      for (int p = 0; p < 4; p++) do_op(NBX_OP_DIRECT, 2'(p), 4'(4'hF - p));
      do_op(NBX_OP_OR, 2'h0, 4'h5);
      do_op(NBX_OP_AND, 2'h1, 4'h7);
      do_op(NBX_OP_AND, 2'h3, 4'h9);
      for (int p = 0; p < 4; p++) begin
         xfer(NBX_OP_READ, 2'(p), 4'h0);
         do_op(NBX_OP_READ, 2'(p), 4'h0);
      end
      do_op(NBX_OP_OR, 2'h2, 4'h9);
      port_pin_in <= 16'h5A6F;
      do_op(NBX_OP_READ, 2'h2, 4'h0);
      complete_run();
   end
endmodule
`default_nettype wire
